// file: hw/fdc_cmd_seq.v
// Command and result byte sequencer of the diskette controller, APB slave
// Functional notes
// - Host writes each command's bytes, device latches all but a rejected opcode byte
// - Result bytes read in fixed order, all of them
// - Unknown opcode: skip execution, return status 3 only
// - Read data: 9 command bytes, 7 result bytes
// - Read deleted data uses read data sequences
// - Format: 6 bytes, flags zero, 7 results
// - No new command until all results read
// - Main status bits 7 and 6 show phase
// - Rejected command loads 80h into status 0
// - Execution end raises interrupt, enters result phase
`timescale 1ns/1ps
`default_nettype none
`include "fdc_seq_map.vh"

module fdc_cmd_seq
(
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Interrupt
  output wire        irq,
  // Execution engine side
  output reg         exec_start,
  output reg  [7:0]  exec_opcode,
  input  wire [3:0]  exec_param_idx,
  output wire [7:0]  exec_param_data,
  input  wire        exec_done,
  input  wire [7:0]  exec_st0,
  input  wire [7:0]  exec_st1,
  input  wire [7:0]  exec_st2,
  input  wire [7:0]  exec_cyl,
  input  wire [7:0]  exec_head,
  input  wire [7:0]  exec_sector,
  input  wire [7:0]  exec_size,
  input  wire [7:0]  drive_status
);

  // Phase states, one-hot
  localparam [2:0] ST_CMD  = 3'b001;
  localparam [2:0] ST_EXEC = 3'b010;
  localparam [2:0] ST_RES  = 3'b100;

  reg [2:0] state_reg;
  reg [3:0] cmd_cnt_reg;
  reg [3:0] cmd_len_reg;
  reg [2:0] res_cnt_reg;
  reg [2:0] res_len_reg;
  reg [7:0] st0_reg;
  reg [7:0] st1_reg;
  reg [7:0] st2_reg;
  reg [7:0] st3_reg;
  reg [7:0] cyl_reg;
  reg [7:0] head_reg;
  reg [7:0] sector_reg;
  reg [7:0] size_reg;
  reg [1:0] irq_sts_reg;
  reg [1:0] irq_mask_reg;

  // Access decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable;
  wire hit_msr  = (paddr == `OFS_MAIN_STATUS);
  wire hit_data = (paddr == `OFS_DATA);
  wire hit_ists = (paddr == `OFS_IRQ_STATUS);
  wire hit_imsk = (paddr == `OFS_IRQ_MASK);
  wire mapped   = hit_msr | hit_data | hit_ists | hit_imsk;
  wire in_cmd   = (state_reg == ST_CMD);
  wire in_res   = (state_reg == ST_RES);

  // Data writes outside command phase, data reads outside result phase and main status writes are refused
  wire data_refused = hit_data & ((pwrite & ~in_cmd) | (~pwrite & ~in_res));
  wire msr_write    = hit_msr & pwrite;
  wire cmd_wr       = access & pwrite & hit_data & in_cmd;
  wire res_rd       = access & ~pwrite & hit_data & in_res;

  assign pready  = 1'b1;
  assign pslverr = access & (~mapped | data_refused | msr_write);

  // Opcode decode of the first command byte
  wire [7:0] op_byte  = pwdata[7:0];
  wire [4:0] op_code  = op_byte[`OPC_CODE_HI:0];
  wire       op_mt    = op_byte[`OPC_MULTI_TRACK];
  wire       op_sk    = op_byte[`OPC_SKIP_DEL];
  reg  [3:0] op_len;
  reg        op_ok;

  // Command length and flag checks per opcode
  always @*
  begin
    op_len = `LEN_CMD_RW;
    op_ok  = 1'b1;
    case (op_code)
      `CMD_READ_DATA,
      `CMD_READ_DEL:   op_len = `LEN_CMD_RW;
      `CMD_WRITE_DATA: op_ok  = ~op_sk;
      `CMD_WRITE_DEL:  op_ok  = ~op_sk;
      `CMD_READ_TRACK: op_ok  = ~op_mt;
      `CMD_FORMAT:
      begin
        op_len = `LEN_CMD_FORMAT;
        op_ok  = ~(op_mt | op_sk);
      end
      `CMD_READ_ID:
      begin
        op_len = `LEN_CMD_READ_ID;
        op_ok  = ~(op_mt | op_sk);
      end
      default:         op_ok  = 1'b0;
    endcase
  end

  wire first_byte = cmd_wr & (cmd_cnt_reg == 4'h0);
  wire reject     = first_byte & ~op_ok;
  wire last_byte  = cmd_wr & ~reject &
                    (cmd_cnt_reg == (first_byte ? op_len : cmd_len_reg) - 4'h1);
  wire last_res   = res_rd & (res_cnt_reg == res_len_reg - 3'h1);

  // Every byte of an accepted command lands at its order slot; a rejected opcode byte is not stored
  param_store param_store_i
  (
    .clk_sys (clk_sys),
    .wr_en   (cmd_wr & ~reject),
    .wr_addr (cmd_cnt_reg),
    .wr_data (pwdata[7:0]),
    .rd_addr (exec_param_idx),
    .rd_data (exec_param_data)
  );

  // Phase sequencing and result capture
  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      state_reg   <= ST_CMD;
      cmd_cnt_reg <= 4'h0;
      cmd_len_reg <= `LEN_CMD_RW;
      res_cnt_reg <= 3'h0;
      res_len_reg <= `LEN_RES_STD;
      exec_start  <= 1'b0;
      exec_opcode <= `BYTE_RESET;
      st0_reg     <= `BYTE_RESET;
      st1_reg     <= `BYTE_RESET;
      st2_reg     <= `BYTE_RESET;
      st3_reg     <= `BYTE_RESET;
      cyl_reg     <= `BYTE_RESET;
      head_reg    <= `BYTE_RESET;
      sector_reg  <= `BYTE_RESET;
      size_reg    <= `BYTE_RESET;
    end
    else
    begin
      exec_start <= 1'b0;
      case (state_reg)
        ST_CMD:
        begin
          if (reject)
          begin
            st0_reg     <= `ST0_INVALID;
            st3_reg     <= drive_status;
            res_len_reg <= `LEN_RES_INVALID;
            res_cnt_reg <= 3'h0;
            state_reg   <= ST_RES;
          end
          else if (last_byte)
          begin
            cmd_cnt_reg <= 4'h0;
            exec_start  <= 1'b1;
            state_reg   <= ST_EXEC;
          end
          else if (cmd_wr)
            cmd_cnt_reg <= cmd_cnt_reg + 4'h1;
          if (first_byte & ~reject)
          begin
            exec_opcode <= op_byte;
            cmd_len_reg <= op_len;
          end
        end
        ST_EXEC:
        begin
          if (exec_done)
          begin
            st0_reg     <= exec_st0;
            st1_reg     <= exec_st1;
            st2_reg     <= exec_st2;
            cyl_reg     <= exec_cyl;
            head_reg    <= exec_head;
            sector_reg  <= exec_sector;
            size_reg    <= exec_size;
            res_len_reg <= `LEN_RES_STD;
            res_cnt_reg <= 3'h0;
            state_reg   <= ST_RES;
          end
        end
        ST_RES:
        begin
          if (last_res)
          begin
            res_cnt_reg <= 3'h0;
            state_reg   <= ST_CMD;
          end
          else if (res_rd)
            res_cnt_reg <= res_cnt_reg + 3'h1;
        end
        default:
          state_reg <= ST_CMD;
      endcase
    end
  end

  // Result byte in fixed order
  reg [7:0] res_byte;
  always @*
  begin
    case (res_cnt_reg)
      3'h0:    res_byte = (res_len_reg == `LEN_RES_INVALID) ?
                          st3_reg : st0_reg;
      3'h1:    res_byte = st1_reg;
      3'h2:    res_byte = st2_reg;
      3'h3:    res_byte = cyl_reg;
      3'h4:    res_byte = head_reg;
      3'h5:    res_byte = sector_reg;
      3'h6:    res_byte = size_reg;
      default: res_byte = `BYTE_RESET;
    endcase
  end

  // Main status: request for master, direction, busy
  wire [7:0] msr_val;
  assign msr_val[`MSR_RQM]  = ~(state_reg == ST_EXEC);
  assign msr_val[`MSR_DIO]  = in_res;
  assign msr_val[5]         = 1'b0;
  assign msr_val[`MSR_BUSY] = ~in_cmd | (cmd_cnt_reg != 4'h0);
  assign msr_val[3:0]       = 4'h0;

  // Read data prepared in the setup cycle
  always @(posedge clk_sys)
  begin
    if (rst)
      prdata <= 32'h0000_0000;
    else if (setup)
    begin
      prdata <= 32'h0000_0000;
      if (hit_msr)
        prdata[7:0] <= msr_val;
      else if (hit_data & in_res)
        prdata[7:0] <= res_byte;
      else if (hit_ists)
        prdata[1:0] <= irq_sts_reg;
      else if (hit_imsk)
        prdata[1:0] <= irq_mask_reg;
    end
  end

  // Sticky events, write one to clear, set wins
  wire [1:0] irq_set;
  assign irq_set[`IRQ_EXEC_DONE] = (state_reg == ST_EXEC) &
                                   exec_done;
  assign irq_set[`IRQ_INVALID]   = reject;
  wire [1:0] irq_clr = (access & pwrite & hit_ists) ? pwdata[1:0] : 2'h0;

  always @(posedge clk_sys)
  begin
    if (rst)
    begin
      irq_sts_reg  <= `IRQ_RESET;
      irq_mask_reg <= `IRQ_RESET;
    end
    else
    begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
      if (access & pwrite & hit_imsk)
        irq_mask_reg <= pwdata[1:0];
    end
  end

  assign irq = |(irq_sts_reg & irq_mask_reg);

endmodule // fdc_cmd_seq

`default_nettype wire

// file: hw/fdc_seq_map.vh
// Register offsets, field positions, opcodes and lengths for the sequencer
`ifndef FDC_SEQ_MAP_VH
`define FDC_SEQ_MAP_VH

// APB byte offsets
`define OFS_MAIN_STATUS 12'h000
`define OFS_DATA        12'h004
`define OFS_IRQ_STATUS  12'h008
`define OFS_IRQ_MASK    12'h00c

// Main status bit positions
`define MSR_RQM         7
`define MSR_DIO         6
`define MSR_BUSY        4

// Interrupt status bit positions
`define IRQ_EXEC_DONE   0
`define IRQ_INVALID     1
`define IRQ_RESET       2'h0

// Opcode byte fields
`define OPC_MULTI_TRACK 7
`define OPC_SKIP_DEL    5
`define OPC_CODE_HI     4

// Command codes in bits 4:0 of the opcode byte
`define CMD_READ_DATA   5'h06
`define CMD_WRITE_DATA  5'h05
`define CMD_READ_DEL    5'h0c
`define CMD_WRITE_DEL   5'h09
`define CMD_READ_TRACK  5'h02
`define CMD_READ_ID     5'h0a
`define CMD_FORMAT      5'h0d

// Byte counts of the command and result phases
`define LEN_CMD_RW      4'h9
`define LEN_CMD_FORMAT  4'h6
`define LEN_CMD_READ_ID 4'h2
`define LEN_RES_STD     3'h7
`define LEN_RES_INVALID 3'h1

// Status register 0 value on a rejected command
`define ST0_INVALID     8'h80
`define BYTE_RESET      8'h00

`endif

// file: hw/param_store.v
// Small memory for the command bytes with a registered read port
`timescale 1ns/1ps
`default_nettype none

module param_store
(
  // Clock
  input  wire       clk_sys,
  // Write port
  input  wire       wr_en,
  input  wire [3:0] wr_addr,
  input  wire [7:0] wr_data,
  // Read port
  input  wire [3:0] rd_addr,
  output reg  [7:0] rd_data
);

  reg [7:0] mem [0:15];

  // Store on write, register the read data
  always @(posedge clk_sys)
  begin
    if (wr_en)
      mem[wr_addr] <= wr_data;
    rd_data <= mem[rd_addr];
  end

endmodule // param_store

`default_nettype wire

// file: test/diskette_cmd_result_sequencer_test.sv
// Self-checking bench for the command and result sequencer
`timescale 1ns/1ps
`default_nettype none
module diskette_cmd_result_sequencer_test;
  logic        clk_sys = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  drive_status = 8'h00, cmd [0:8];
  logic [3:0]  delay = 4'h0, pidx;
  wire  [31:0] prdata;
  wire         pready, pslverr, irq, start, done;
  wire  [7:0]  opc, pdat, s0, s1, s2, cy, hd, sc, sz;
  logic [65:0] exp_q [$];
  // Valid opcodes first, then an unknown code and four that set a must-be-zero flag
  logic [7:0]  ops [0:11] = '{8'he6, 8'h45, 8'hac,
    8'hc9, 8'h62,
    8'h4a, 8'h4d, 8'h1f, 8'h25, 8'h82, 8'h8a, 8'h2d};
  int          lens [0:11] = '{9, 9, 9, 9, 9, 2, 6, 1, 1, 1, 1, 1};
  int          bad_count = 0, num_checks = 0, cycles = 0, n_start = 0;
  int          seed = 32'h0343530a;
  fdc_cmd_seq fdc_cmd_seq_i (.clk_sys(clk_sys), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .exec_start(start), .exec_opcode(opc), .exec_param_idx(pidx),
    .exec_param_data(pdat), .exec_done(done), .exec_st0(s0),
    .exec_st1(s1), .exec_st2(s2), .exec_cyl(cy), .exec_head(hd),
    .exec_sector(sc), .exec_size(sz), .drive_status(drive_status));
  exec_engine_model exec_engine_model_i (.clk_sys(clk_sys), .rst(rst),
    .exec_start(start), .exec_opcode(opc), .exec_param_data(pdat),
    .exec_param_idx(pidx), .exec_done(done), .exec_st0(s0),
    .exec_st1(s1), .exec_st2(s2), .exec_cyl(cy), .exec_head(hd),
    .exec_sector(sc), .exec_size(sz), .delay(delay));
  always #10 clk_sys = ~clk_sys;
  task chk(input logic [32:0] s, input logic [32:0] e);
    num_checks++;
    if (s !== e)
    begin
      bad_count++;
      $display("CHECK FAILED %0t seen %h want %h", $time, s, e);
    end
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // Transfer with its note {care mask, error and data}
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
    input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back({m, e & m});
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask
  task w(input logic [11:0] a, input logic [7:0] d, input logic er);
    apb(1'b1, a, {24'h0, d}, {er, 32'h0}, {1'b1, 32'h0});
  endtask
  task r(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic er);
    apb(1'b0, a, 32'h0, {er, e}, {1'b1, m});
  endtask
  // Compare each finished transfer with the oldest note
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (start === 1'b1)
      n_start <= n_start + 1;
    if (psel && penable && pready && exp_q.size() > 0)
    begin
      chk({pslverr, prdata} & exp_q[0][65:33],
        exp_q[0][32:0]);
      exp_q.delete(0);
    end
    if (cycles == 8000)
    begin
      bad_count++;
      stop_test();
    end
  end
  // One command, its execution and its result bytes
  task seqc(input logic [7:0] op, input int len);
    int k, n0, nres;
    nres = len > 1 ? 7 : 1;
    n0 = n_start;
    cmd[0] = op;
    for (k = 1; k < 9; k++)
      cmd[k] = 8'($random(seed));
    delay <= 4'($random(seed));
    drive_status <= 8'($random(seed));
    for (k = 0; k < len; k++)
      w(12'h004, cmd[k], 1'b0);
    if (nres > 1)
    begin
      w(12'h004, 8'h00, 1'b1);
      r(12'h000, 32'h0, 32'h80, 1'b0);
    end
    for (k = 0; k < 200 && irq !== 1'b1; k++)
      @(posedge clk_sys);
    chk({32'h0, irq}, 33'h1);
    r(12'h000, 32'hc0, 32'hc0, 1'b0);
    r(12'h008, nres > 1 ? 32'h1 : 32'h2, 32'h3, 1'b0);
    // Masking a pending event must drop the request line
    w(12'h00c, 8'h00, 1'b0);
    chk({32'h0, irq}, 33'h0);
    w(12'h00c, 8'h03, 1'b0);
    w(12'h008, 8'h03, 1'b0);
    chk({32'h0, irq}, 33'h0);
    for (k = 0; k < nres; k++)
    begin
      r(12'h004, nres == 1 ? drive_status : k == 4 ? cmd[1] : op + k,
        32'hff, 1'b0);
      if (k == 2)
        w(12'h004, 8'h00, 1'b1);
    end
    r(12'h004, 32'h0, 32'h0, 1'b1);
    r(12'h000, 32'h80, 32'hc0, 1'b0);
    chk(33'(n_start - n0), nres > 1 ? 33'h1 : 33'h0);
  endtask
  // Reset, register checks, then every command and bad opcodes
  initial
  begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    r(12'h000, 32'h80, 32'hff, 1'b0);
    w(12'h000, 8'h00, 1'b1);
    w(12'h00c, 8'h03, 1'b0);
    r(12'h00c, 32'h3, 32'h3, 1'b0);
    r(12'h010, 32'h0, 32'h0, 1'b1);
    for (int i = 0; i < 12; i++)
      seqc(ops[i], lens[i]);
    stop_test();
  end
endmodule // diskette_cmd_result_sequencer_test
`default_nettype wire

// file: test/exec_engine_model.sv
// Execution engine stand-in answering start pulses
`timescale 1ns/1ps
`default_nettype none
module exec_engine_model
(
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst,
  // Sequencer side
  input  wire logic       exec_start,
  input  wire logic [7:0] exec_opcode,
  input  wire logic [7:0] exec_param_data,
  output var  logic [3:0] exec_param_idx,
  output var  logic       exec_done,
  output wire logic [7:0] exec_st0,
  output wire logic [7:0] exec_st1,
  output wire logic [7:0] exec_st2,
  output wire logic [7:0] exec_cyl,
  output wire logic [7:0] exec_head,
  output wire logic [7:0] exec_sector,
  output wire logic [7:0] exec_size,
  // Extra execution cycles
  input  wire logic [3:0] delay
);
  logic [4:0] cnt_reg;
  logic       run_reg;
  logic [7:0] head_reg;
  // Results valid with the done pulse only, inverted otherwise
  wire  [7:0] op = exec_done ? exec_opcode : ~exec_opcode;
  assign exec_st0 = op;
  assign exec_st1 = op + 8'h01;
  assign exec_st2 = op + 8'h02;
  assign exec_cyl = op + 8'h03;
  assign exec_head = exec_done ? head_reg : ~head_reg;
  assign exec_sector = op + 8'h05;
  assign exec_size = op + 8'h06;
  // Reads back the drive/head slot, then finishes
  always @(posedge clk_sys)
  begin
    exec_done <= 1'b0;
    exec_param_idx <= 4'h1;
    if (rst)
      run_reg <= 1'b0;
    else if (exec_start)
    begin
      run_reg <= 1'b1;
      cnt_reg <= {1'b0, delay} + 5'h8;
    end
    else if (run_reg)
    begin
      cnt_reg <= cnt_reg - 5'h1;
      head_reg <= exec_param_data;
      run_reg <= cnt_reg != 5'h0;
      exec_done <= cnt_reg == 5'h0;
    end
  end
endmodule // exec_engine_model
`default_nettype wire

// file: test/fdc_cmd_seq_monitor.sv
// Assertion checker for the command sequencer ports
`timescale 1ns/1ps
`default_nettype none
module fdc_cmd_seq_monitor
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  // Interrupt and engine
  input wire logic        irq,
  input wire logic        exec_start,
  input wire logic        exec_done
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  wire        acc = psel && penable;
  wire        rd_setup = psel && !penable && !pwrite;
  wire        dwr = acc && pwrite && paddr == 12'h004;
  logic       busy_reg;
  logic [1:0] mask_reg;
  // Execution tracker and mask copy
  always @(posedge clk_sys)
  begin
    if (rst || exec_done)
      busy_reg <= 1'b0;
    else if (exec_start)
      busy_reg <= 1'b1;
    if (rst)
      mask_reg <= 2'h0;
    else if (acc && pwrite && paddr == 12'h00c)
      mask_reg <= pwdata[1:0];
  end
  property p_pulse; exec_start |=> !exec_start; endproperty
  a_pulse: assert property (p_pulse)
    else $error("start pulse too long");
  property p_cause; exec_start |-> $past(dwr); endproperty
  a_cause: assert property (p_cause)
    else $error("start without a command byte");
  property p_nostart; busy_reg |-> !exec_start; endproperty
  a_nostart: assert property (p_nostart)
    else $error("second start in execution");
  property p_refuse; busy_reg && acc && paddr == 12'h004 |-> pslverr;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("data access accepted in execution");
  property p_phase; busy_reg && rd_setup && paddr == 12'h000 |=> !prdata[7];
  endproperty
  a_phase: assert property (p_phase)
    else $error("status shows request in execution");
  property p_ro; acc && pwrite && paddr == 12'h000 |-> pslverr; endproperty
  a_ro: assert property (p_ro)
    else $error("status write accepted");
  property p_mask; mask_reg == 2'h0 && $past(mask_reg) == 2'h0 |-> !irq;
  endproperty
  a_mask: assert property (p_mask)
    else $error("interrupt while masked");
  property p_upper; rd_setup |=> prdata[31:8] == 24'h0; endproperty
  a_upper: assert property (p_upper)
    else $error("read data upper bits set");
endmodule // fdc_cmd_seq_monitor
bind fdc_cmd_seq fdc_cmd_seq_monitor fdc_cmd_seq_monitor_i (
  .clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pslverr(pslverr), .irq(irq), .exec_start(exec_start),
  .exec_done(exec_done));
`default_nettype wire
